// *** common/hbms_defines.vh ***
`ifndef HBMS_DEFINES_VH
`define HBMS_DEFINES_VH

// Host bus protocol codes on the three strap inputs
`define HBMS_MODE_ISA 3'h0
`define HBMS_MODE_EISA 3'h1
`define HBMS_MODE_VLB 3'h2
`define HBMS_MODE_PCI 3'h3
`define HBMS_MODE_MCA 3'h4

// Slot-relative configuration window, EISA
`define HBMS_EISA_CFG_LO 12'hC80
`define HBMS_EISA_CFG_HI 12'hC84
// Base of the configuration window, MCA
`define HBMS_MCA_CFG_BASE 12'h100
// Number of configuration bytes
`define HBMS_CFG_NUM 12'h005

// Configuration byte indices
`define HBMS_CFG_ID_LO 3'h0
`define HBMS_CFG_ID_HI 3'h1
`define HBMS_CFG_BUS_ON 3'h2
`define HBMS_CFG_BUS_OFF 3'h3
`define HBMS_CFG_CTRL 3'h4

// Configuration reset values
`define HBMS_BUS_ON_RST 8'h08
`define HBMS_BUS_OFF_RST 8'h04
`define HBMS_CTRL_RST 8'h00

// Timer tick: one microsecond at a 25 ns clock, rounded up
`define HBMS_TICK_NS 16'h03E8
`define HBMS_CLK_NS 16'h0019
`define HBMS_TICK_CYC ((`HBMS_TICK_NS + `HBMS_CLK_NS - 16'h0001) / `HBMS_CLK_NS)

// Data buffer: 16 words of 64 bits make 128 bytes
`define HBMS_FIFO_W 64
`define HBMS_FIFO_DEPTH 16
`define HBMS_FIFO_AW 4

`endif

// *** core/hbms_fifo.v ***
`timescale 1ns/100ps
module hbms_fifo #(
   parameter W = 64,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire clk,
   input wire rst,
   input wire in_valid,
   output wire in_ready,
   input wire [W-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [W-1:0] out_data
);
   reg [W-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_q;
   reg [AW-1:0] rd_q;
   reg [AW:0] cnt_q;
   wire push;
   wire pop;

   // Full and empty come from the occupancy count, so no slot is wasted
   assign in_ready = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem[rd_q];

   // Storage array, written without reset
   always @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_q] <= in_data;
      end
   end

   // Pointers and count
   always @(posedge clk)
   begin
      if (rst)
      begin
         wr_q <= {AW{1'b0}};
         rd_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
            wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
         if (pop)
            rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
         if (push & ~pop)
            cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
         else if (pop & ~push)
            cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
      end
   end
endmodule

// *** core/hbms_cfg.v ***
`timescale 1ns/100ps
`include "hbms_defines.vh"
module hbms_cfg #(
   parameter [15:0] ADAPTER_ID = 16'h5A5A // Arbitrary value
) (
   input wire clk,
   input wire rst,
   input wire [2:0] mode,
   input wire [11:0] io_addr,
   input wire io_rd,
   input wire io_wr,
   input wire [7:0] io_wdata,
   input wire aen_slot,
   input wire cd_setup,
   input wire loc_wr,
   input wire [2:0] loc_addr,
   input wire [7:0] loc_wdata,
   output reg [7:0] io_rdata,
   output wire io_hit,
   output wire [7:0] bus_on,
   output wire [7:0] bus_off
);
   reg [7:0] bus_on_q;
   reg [7:0] bus_off_q;
   reg [7:0] ctrl_q;
   wire eisa_hit;
   wire mca_hit;
   wire [11:0] mca_off;
   wire [2:0] idx;
   wire host_mode;

   // Same address window in every slot; the slot enable picks the card
   assign eisa_hit = (mode == `HBMS_MODE_EISA) & aen_slot &
                     (io_addr >= `HBMS_EISA_CFG_LO) & (io_addr <= `HBMS_EISA_CFG_HI);
   assign mca_off = io_addr - `HBMS_MCA_CFG_BASE;
   assign mca_hit = (mode == `HBMS_MODE_MCA) & cd_setup &
                    (io_addr >= `HBMS_MCA_CFG_BASE) & (mca_off < `HBMS_CFG_NUM);
   assign io_hit = eisa_hit | mca_hit;
   assign idx = eisa_hit ? io_addr[2:0] : mca_off[2:0];
   assign host_mode = (mode == `HBMS_MODE_EISA) | (mode == `HBMS_MODE_MCA);
   assign bus_on = bus_on_q;
   assign bus_off = bus_off_q;

   // Writable bytes; host writes only in slot-configured buses, local writes elsewhere
   always @(posedge clk)
   begin
      if (rst)
      begin
         bus_on_q <= `HBMS_BUS_ON_RST;
         bus_off_q <= `HBMS_BUS_OFF_RST;
         ctrl_q <= `HBMS_CTRL_RST;
      end
      else if (io_wr & io_hit)
      begin
         if (idx == `HBMS_CFG_BUS_ON)
            bus_on_q <= io_wdata;
         if (idx == `HBMS_CFG_BUS_OFF)
            bus_off_q <= io_wdata;
         if (idx == `HBMS_CFG_CTRL)
            ctrl_q <= io_wdata;
      end
      else if (loc_wr & ~host_mode)
      begin
         if (loc_addr == `HBMS_CFG_BUS_ON)
            bus_on_q <= loc_wdata;
         if (loc_addr == `HBMS_CFG_BUS_OFF)
            bus_off_q <= loc_wdata;
         if (loc_addr == `HBMS_CFG_CTRL)
            ctrl_q <= loc_wdata;
      end
   end

   // Read data held until the next decoded read; the identifier is read only
   always @(posedge clk)
   begin
      if (rst)
         io_rdata <= 8'h00;
      else if (io_rd & io_hit)
      begin
         case (idx)
            `HBMS_CFG_ID_LO: io_rdata <= ADAPTER_ID[7:0];
            `HBMS_CFG_ID_HI: io_rdata <= ADAPTER_ID[15:8];
            `HBMS_CFG_BUS_ON: io_rdata <= bus_on_q;
            `HBMS_CFG_BUS_OFF: io_rdata <= bus_off_q;
            `HBMS_CFG_CTRL: io_rdata <= ctrl_q;
            default: io_rdata <= 8'h00;
         endcase
      end
   end
endmodule

// *** core/hbms_top.v ***
// Function
// - The bus protocol follows the three strap inputs that are tied on the board.
// - A programmed transfer starts arbitration by itself by raising the bus request.
// - In ISA the request is the DMA request and nothing further happens until acknowledge.
// - After the grant MASTER is raised first and only then does data move.
// - As master the engine drives address and the memory read and write strobes.
// - Transfer goes on until count ends, FIFO is empty or full, or the host wants the bus.
// - Release drops MASTER and floats address and data before the request falls.
// - In EISA the slot window C80 to C84 answers only while the slot enable is high.
// - In MCA configuration access, identifier included, needs setup plus a matching address.
// - In ISA and VL-Bus the configuration is written by the local controller only.
// - Mailbox entries are fetched and cleared in host memory by the engine alone.
// - Host preemption ends the tenure through the normal release sequence.
// - In ISA a bus-on timer limits tenure and a bus-off timer delays the next request.
// - Transfer data passes through an internal 128-byte FIFO.
`timescale 1ns/100ps
`include "hbms_defines.vh"
module hbms_top (
   input wire REF_CLK,
   input wire RST,
   input wire [2:0] MODE_SEL,
   input wire PROG_VALID,
   output wire PROG_READY,
   input wire [31:0] PROG_ADDR,
   input wire [15:0] PROG_CNT,
   input wire PROG_TO_MEM,
   input wire PROG_MBOX,
   output wire XFER_DONE,
   output wire MBOX_VALID,
   output wire [31:0] MBOX_ENTRY,
   input wire [63:0] LOC_IN_DATA,
   input wire LOC_IN_VALID,
   output wire LOC_IN_READY,
   output wire [63:0] LOC_OUT_DATA,
   output wire LOC_OUT_VALID,
   input wire LOC_OUT_READY,
   output wire BUS_REQ,
   input wire BUS_ACK,
   input wire BUS_PREEMPT,
   output wire MASTER,
   output wire [31:0] HA_OUT,
   output wire HA_OE_N,
   input wire [31:0] HD_IN,
   output wire [31:0] HD_OUT,
   output wire HD_OE_N,
   output wire MEMR,
   output wire MEMW,
   input wire BUS_RDY,
   input wire [11:0] IO_ADDR,
   input wire IO_RD,
   input wire IO_WR,
   input wire [7:0] IO_WDATA,
   output wire [7:0] IO_RDATA,
   output wire IO_DOE_N,
   input wire AEN_SLOT,
   input wire CDSETUP,
   input wire LCFG_WR,
   input wire [2:0] LCFG_ADDR,
   input wire [7:0] LCFG_DATA
);
   localparam [3:0] S_IDLE = 4'h0;
   localparam [3:0] S_REQ = 4'h1;
   localparam [3:0] S_MAST = 4'h2;
   localparam [3:0] S_XCHK = 4'h3;
   localparam [3:0] S_XCYC = 4'h4;
   localparam [3:0] S_REL1 = 4'h5;
   localparam [3:0] S_REL2 = 4'h6;
   localparam [3:0] S_OFF = 4'h7;
   localparam [3:0] S_DONE = 4'h8;

   reg [3:0] st_q;
   reg [31:0] addr_q;
   reg [15:0] cnt_q;
   reg dir_q;
   reg mbox_q;
   reg mph_q;
   reg fin_q;
   reg half_q;
   reg [31:0] lo_q;
   reg [31:0] hd_out_q;
   reg [31:0] entry_q;
   reg [15:0] on_cnt_q;
   reg on_lim_q;
   reg [15:0] off_cnt_q;
   reg done_q;
   reg mbox_vld_q;

   wire is_isa;
   wire [7:0] bus_on;
   wire [7:0] bus_off;
   wire fifo_in_valid;
   wire fifo_in_ready;
   wire [63:0] fifo_in_data;
   wire fifo_out_valid;
   wire fifo_out_ready;
   wire [63:0] fifo_out_data;
   wire bus_done;
   wire bus_push;
   wire bus_pop;
   wire fifo_can;
   wire on_expired;
   wire stop_now;
   wire all_done;
   wire cyc_wr;
   wire in_tenure;
   wire cfg_hit;

   // Timer loads in microsecond ticks; width covers 255 ticks of 40 cycles
   function [15:0] tick_cycles;
      input [7:0] n;
      begin
         tick_cycles = {8'h00, n} * `HBMS_TICK_CYC;
      end
   endfunction

   // Protocol picked from the static straps; no register, straps never change in use
   assign is_isa = (MODE_SEL == `HBMS_MODE_ISA);

   hbms_cfg u_cfg (
      .clk(REF_CLK),
      .rst(RST),
      .mode(MODE_SEL),
      .io_addr(IO_ADDR),
      .io_rd(IO_RD),
      .io_wr(IO_WR),
      .io_wdata(IO_WDATA),
      .aen_slot(AEN_SLOT),
      .cd_setup(CDSETUP),
      .loc_wr(LCFG_WR),
      .loc_addr(LCFG_ADDR),
      .loc_wdata(LCFG_DATA),
      .io_rdata(IO_RDATA),
      .io_hit(cfg_hit),
      .bus_on(bus_on),
      .bus_off(bus_off)
   );
   assign IO_DOE_N = ~(IO_RD & cfg_hit);

   // One FIFO serves both directions; the direction of the last program owns it
   hbms_fifo #(
      .W(`HBMS_FIFO_W),
      .DEPTH(`HBMS_FIFO_DEPTH),
      .AW(`HBMS_FIFO_AW)
   ) u_fifo (
      .clk(REF_CLK),
      .rst(RST),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   // A bus word completes on the ready; the high half closes a FIFO word
   assign bus_done = (st_q == S_XCYC) & BUS_RDY;
   assign bus_push = bus_done & ~dir_q & half_q & ~mbox_q;
   assign bus_pop = bus_done & dir_q & half_q & ~mbox_q;
   assign fifo_in_valid = dir_q ? LOC_IN_VALID : bus_push;
   assign fifo_in_data = dir_q ? LOC_IN_DATA : {HD_IN, lo_q};
   assign fifo_out_ready = dir_q ? bus_pop : LOC_OUT_READY;
   assign LOC_IN_READY = dir_q & fifo_in_ready;
   assign LOC_OUT_VALID = ~dir_q & fifo_out_valid;
   assign LOC_OUT_DATA = fifo_out_data;

   // Data can move when the FIFO has a word to send or room to take one
   assign fifo_can = dir_q ? fifo_out_valid : fifo_in_ready;
   assign on_expired = on_lim_q & (on_cnt_q == 16'h0000);
   // Stop checks happen only between bus words, so a started word always finishes
   assign stop_now = mbox_q ? (fin_q | BUS_PREEMPT) :
                     ((cnt_q == 16'h0000) | BUS_PREEMPT | on_expired | (~half_q & ~fifo_can));
   assign all_done = mbox_q ? fin_q : (cnt_q == 16'h0000);

   // Bus pins follow the state; nothing is driven outside the master window
   assign in_tenure = (st_q == S_MAST) | (st_q == S_XCHK) | (st_q == S_XCYC);
   assign cyc_wr = mbox_q ? mph_q : dir_q;
   assign BUS_REQ = in_tenure | (st_q == S_REQ) | (st_q == S_REL1);
   assign MASTER = in_tenure;
   assign HA_OUT = addr_q;
   assign HA_OE_N = ~in_tenure;
   assign HD_OUT = hd_out_q;
   assign HD_OE_N = ~((st_q == S_XCYC) & cyc_wr);
   assign MEMR = (st_q == S_XCYC) & ~cyc_wr;
   assign MEMW = (st_q == S_XCYC) & cyc_wr;
   assign PROG_READY = (st_q == S_IDLE);
   assign XFER_DONE = done_q;
   assign MBOX_VALID = mbox_vld_q;
   assign MBOX_ENTRY = entry_q;

   // Transfer sequencer: arbitrate, master, move words, release, rest
   always @(posedge REF_CLK)
   begin
      if (RST)
      begin
         st_q <= S_IDLE;
         addr_q <= 32'h0000_0000;
         cnt_q <= 16'h0000;
         dir_q <= 1'b0;
         mbox_q <= 1'b0;
         mph_q <= 1'b0;
         fin_q <= 1'b0;
         half_q <= 1'b0;
         lo_q <= 32'h0000_0000;
         hd_out_q <= 32'h0000_0000;
         entry_q <= 32'h0000_0000;
         on_cnt_q <= 16'h0000;
         on_lim_q <= 1'b0;
         off_cnt_q <= 16'h0000;
         done_q <= 1'b0;
         mbox_vld_q <= 1'b0;
      end
      else
      begin
         done_q <= 1'b0;
         mbox_vld_q <= 1'b0;
         if (on_cnt_q != 16'h0000)
            on_cnt_q <= on_cnt_q - 16'h0001;
         case (st_q)
            S_IDLE:
            begin
               if (PROG_VALID)
               begin
                  addr_q <= PROG_ADDR;
                  cnt_q <= PROG_CNT;
                  dir_q <= PROG_TO_MEM;
                  mbox_q <= PROG_MBOX;
                  mph_q <= 1'b0;
                  fin_q <= 1'b0;
                  half_q <= 1'b0;
                  st_q <= S_REQ;
               end
            end
            S_REQ:
            begin
               // Hold the request and do nothing else until the grant
               if (BUS_ACK)
                  st_q <= S_MAST;
            end
            S_MAST:
            begin
               // MASTER shows for two cycles (here and in S_XCHK) before the first strobe
               on_cnt_q <= tick_cycles(bus_on);
               on_lim_q <= is_isa & (bus_on != 8'h00);
               st_q <= S_XCHK;
            end
            S_XCHK:
            begin
               if (stop_now)
                  st_q <= S_REL1;
               else
               begin
                  if (mbox_q)
                     hd_out_q <= 32'h0000_0000;
                  else if (half_q)
                     hd_out_q <= fifo_out_data[63:32];
                  else
                     hd_out_q <= fifo_out_data[31:0];
                  st_q <= S_XCYC;
               end
            end
            S_XCYC:
            begin
               if (BUS_RDY)
               begin
                  if (mbox_q)
                  begin
                     // Read the entry, then write zero back to free the slot
                     if (~mph_q)
                     begin
                        entry_q <= HD_IN;
                        if (HD_IN != 32'h0000_0000)
                           mph_q <= 1'b1;
                        else
                           fin_q <= 1'b1;
                     end
                     else
                        fin_q <= 1'b1;
                  end
                  else
                  begin
                     addr_q <= addr_q + 32'h0000_0004;
                     half_q <= ~half_q;
                     if (half_q)
                        cnt_q <= cnt_q - 16'h0001;
                     if (~half_q & ~dir_q)
                        lo_q <= HD_IN;
                  end
                  st_q <= S_XCHK;
               end
            end
            S_REL1:
            begin
               // MASTER and drivers already off; request still held this cycle
               st_q <= S_REL2;
            end
            S_REL2:
            begin
               // Wait for the host to drop its acknowledge before moving on
               if (~BUS_ACK)
               begin
                  if (all_done)
                     st_q <= S_DONE;
                  else
                  begin
                     off_cnt_q <= is_isa ? tick_cycles(bus_off) : 16'h0000;
                     st_q <= S_OFF;
                  end
               end
            end
            S_OFF:
            begin
               // Rest off the bus, then ask again once data can flow
               if (off_cnt_q != 16'h0000)
                  off_cnt_q <= off_cnt_q - 16'h0001;
               else if (fifo_can | mbox_q)
                  st_q <= S_REQ;
            end
            S_DONE:
            begin
               done_q <= 1'b1;
               mbox_vld_q <= mbox_q & (entry_q != 32'h0000_0000);
               st_q <= S_IDLE;
            end
            default:
            begin
               st_q <= S_IDLE;
            end
         endcase
      end
   end
endmodule

// *** testbench/hbms_top_asserts.sv ***
`timescale 1ns/100ps
module hbms_top_asserts (
   input wire REF_CLK,
   input wire RST,
   input wire PROG_VALID,
   input wire PROG_READY,
   input wire XFER_DONE,
   input wire BUS_REQ,
   input wire BUS_ACK,
   input wire MASTER,
   input wire [31:0] HA_OUT,
   input wire HA_OE_N,
   input wire HD_OE_N,
   input wire MEMR,
   input wire MEMW,
   input wire BUS_RDY
);
   // One clock domain, so clocking and reset masking are shared
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RST);
   // Arbitration ahead of any master activity
   take_req_a: assert property (PROG_VALID && PROG_READY |=> BUS_REQ && !MASTER)
      else $error("no request after program");
   grant_first_a: assert property ($rose(MASTER) |-> BUS_REQ && $past(BUS_ACK))
      else $error("master without grant");
   wait_grant_a: assert property (BUS_REQ && !BUS_ACK && !MASTER |=> !MASTER)
      else $error("master before acknowledge");
   // Strobes only inside a master window, one at a time
   strobe_master_a: assert property ((MEMR || MEMW) |->
      MASTER && !HA_OE_N && $past(MASTER) && !(MEMR && MEMW))
      else $error("strobe outside master window");
   data_drive_a: assert property (!HD_OE_N |-> MEMW)
      else $error("data driven without write strobe");
   strobe_hold_a: assert property ((MEMR || MEMW) && !BUS_RDY |=> $stable({MEMR, MEMW}) && $stable(HA_OUT))
      else $error("strobe cycle changed before ready");
   // Release order: master and drivers first, request last
   float_first_a: assert property ($fell(MASTER) |-> BUS_REQ && HA_OE_N && HD_OE_N)
      else $error("request dropped with master");
   req_last_a: assert property ($fell(BUS_REQ) |-> !MASTER && !$past(MASTER))
      else $error("request fell while master");
   done_idle_a: assert property (XFER_DONE |-> !BUS_REQ && !MASTER ##1 !XFER_DONE && PROG_READY)
      else $error("done while holding the bus");
endmodule
bind hbms_top hbms_top_asserts i_hbms_top_asserts (.REF_CLK(REF_CLK), .RST(RST), .PROG_VALID(PROG_VALID),
   .PROG_READY(PROG_READY), .XFER_DONE(XFER_DONE), .BUS_REQ(BUS_REQ), .BUS_ACK(BUS_ACK), .MASTER(MASTER),
   .HA_OUT(HA_OUT), .HA_OE_N(HA_OE_N), .HD_OE_N(HD_OE_N), .MEMR(MEMR), .MEMW(MEMW), .BUS_RDY(BUS_RDY));

// *** testbench/hbms_host_model.sv ***
`timescale 1ns/100ps
module hbms_host_model (
   input wire clk,
   input wire rst,
   input wire [3:0] slow,
   input wire bus_req,
   input wire [31:0] ha,
   input wire [31:0] hd_out,
   input wire memr,
   input wire memw,
   output logic bus_ack,
   output logic bus_rdy,
   output wire [31:0] hd_in
);
   logic [31:0] mem [0:255];
   logic [31:0] last_q;
   logic [3:0] a_q;
   logic [3:0] s_q;
   // Data only under the read strobe; else a toggling pattern so stale data is never seen
   assign hd_in = memr ? mem[ha[9:2]] : ~last_q;
   // Grant and ready each come slow+1 cycles late
   always @(posedge clk)
   begin
      if (rst)
      begin
         last_q <= 32'h0000_0000;
         {bus_ack, bus_rdy, a_q, s_q} <= 10'h000;
      end
      else
      begin
         last_q <= hd_in;
         a_q <= (bus_req && !bus_ack) ? a_q + 4'h1 : 4'h0;
         bus_ack <= bus_req && (bus_ack || a_q >= slow);
         s_q <= ((memr || memw) && !bus_rdy) ? s_q + 4'h1 : 4'h0;
         bus_rdy <= (memr || memw) && !bus_rdy && s_q >= slow;
         if (memw && bus_rdy)
            mem[ha[9:2]] <= hd_out;
      end
   end
endmodule

// *** testbench/testbench.sv ***
`timescale 1ns/100ps
module testbench;
   logic ref_clk, rst, prog_valid, prog_to_mem, prog_mbox, loc_in_valid, loc_out_ready, bus_preempt;
   logic io_rd, io_wr, aen_slot, cdsetup, lcfg_wr;
   logic [2:0] mode_sel, lcfg_addr;
   logic [31:0] prog_addr;
   logic [15:0] prog_cnt;
   logic [63:0] loc_in_data;
   logic [11:0] io_addr;
   logic [7:0] io_wdata, lcfg_data;
   logic [3:0] slow;
   wire prog_ready, xfer_done, mbox_valid, loc_in_ready, loc_out_valid, bus_req, bus_ack, master;
   wire ha_oe_n, hd_oe_n, memr, memw, bus_rdy, io_doe_n;
   wire [31:0] mbox_entry, ha_out, hd_in, hd_out;
   wire [63:0] loc_out_data;
   wire [7:0] io_rdata;
   integer error_cnt = 0;
   integer n_tests = 0;
   integer cycles = 0;

   hbms_top i_hbms_top (.REF_CLK(ref_clk), .RST(rst), .MODE_SEL(mode_sel), .PROG_VALID(prog_valid),
      .PROG_READY(prog_ready), .PROG_ADDR(prog_addr), .PROG_CNT(prog_cnt), .PROG_TO_MEM(prog_to_mem),
      .PROG_MBOX(prog_mbox), .XFER_DONE(xfer_done), .MBOX_VALID(mbox_valid), .MBOX_ENTRY(mbox_entry),
      .LOC_IN_DATA(loc_in_data), .LOC_IN_VALID(loc_in_valid), .LOC_IN_READY(loc_in_ready),
      .LOC_OUT_DATA(loc_out_data), .LOC_OUT_VALID(loc_out_valid), .LOC_OUT_READY(loc_out_ready),
      .BUS_REQ(bus_req), .BUS_ACK(bus_ack), .BUS_PREEMPT(bus_preempt), .MASTER(master), .HA_OUT(ha_out),
      .HA_OE_N(ha_oe_n), .HD_IN(hd_in), .HD_OUT(hd_out), .HD_OE_N(hd_oe_n), .MEMR(memr), .MEMW(memw),
      .BUS_RDY(bus_rdy), .IO_ADDR(io_addr), .IO_RD(io_rd), .IO_WR(io_wr), .IO_WDATA(io_wdata),
      .IO_RDATA(io_rdata), .IO_DOE_N(io_doe_n), .AEN_SLOT(aen_slot), .CDSETUP(cdsetup),
      .LCFG_WR(lcfg_wr), .LCFG_ADDR(lcfg_addr), .LCFG_DATA(lcfg_data));
   hbms_host_model i_hbms_host_model (.clk(ref_clk), .rst(rst), .slow(slow), .bus_req(bus_req),
      .ha(ha_out), .hd_out(hd_out), .memr(memr), .memw(memw), .bus_ack(bus_ack), .bus_rdy(bus_rdy),
      .hd_in(hd_in));

   // Clock source
   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // Watchdog, far above the roughly 1200 cycles the sequence needs
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         error_cnt++;
         give_verdict;
      end
   end
   task give_verdict;
      $display("errors=%0d checks=%0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input [63:0] got, input [63:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Inputs always move 1 ns after the rising edge
   task cyc(input integer n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // Bounded wait: 0 done pulse, 1 master up, 2 master down
   task automatic wt(input integer w);
      integer i;
      for (i = 0; i < 3000 && (w == 0 ? xfer_done : w == 1 ? master : !master) !== 1'b1; i++)
         cyc(1);
      chk(i < 3000, 1);
   endtask
   // Programs start one cycle after the done pulse, never inside it
   task automatic prog(input logic tm, input logic mb, input [31:0] a, input [15:0] n);
      cyc(1);
      {prog_to_mem, prog_mbox, prog_addr, prog_cnt, prog_valid} = {tm, mb, a, n, 1'b1};
      cyc(1);
      prog_valid = 1'b0;
      chk(bus_req, 1);
   endtask
   function automatic [63:0] pat(input integer k);
      pat = {32'hB000_0000 + k, 32'hA000_0000 + k};
   endfunction
   task automatic push(input integer k0, input integer n, output integer got);
      loc_in_valid = 1'b1;
      for (got = 0; got < n && loc_in_ready === 1'b1; got++)
      begin
         loc_in_data = pat(k0 + got);
         cyc(1);
      end
      loc_in_valid = 1'b0;
   endtask
   // Drain the local side in order until all words and the done pulse are seen
   task automatic drain(input integer n);
      integer i, k = 0, seen = 0;
      loc_out_ready = 1'b1;
      for (i = 0; i < 3000 && (k < n || seen == 0); i++)
      begin
         seen = seen | (xfer_done === 1'b1);
         if (loc_out_valid === 1'b1)
            chk(loc_out_data, pat(k));
         k = k + (loc_out_valid === 1'b1);
         cyc(1);
      end
      loc_out_ready = 1'b0;
      chk(k, n);
   endtask
   // Host config access: a write, or a read with expected decode and data
   task automatic io(input logic wr, input [11:0] a, input [7:0] d, input logic hit);
      {io_addr, io_wdata, io_wr, io_rd} = {a, d, wr, !wr};
      #1;
      if (!wr)
         chk(io_doe_n, !hit);
      cyc(1);
      {io_wr, io_rd} = 2'h0;
      if (!wr && hit)
         chk(io_rdata, d);
      cyc(1);
   endtask
   task reset_mode(input [2:0] m);
      {mode_sel, rst} = {m, 1'b1};
      cyc(5);
      rst = 1'b0;
   endtask
   // Config windows follow the strap setting and the slot qualifiers
   task t_cfg;
      reset_mode(3'h1);
      aen_slot = 1'b1;
      io(0, 12'hC80, 8'h5A, 1);
      io(0, 12'hC83, 8'h04, 1);
      io(0, 12'hC85, 8'h00, 0);
      io(1, 12'hC81, 8'hFF, 1);
      io(1, 12'hC82, 8'h33, 1);
      {lcfg_addr, lcfg_data, lcfg_wr} = {3'h2, 8'h77, 1'b1};
      cyc(1);
      lcfg_wr = 1'b0;
      io(0, 12'hC82, 8'h33, 1);
      io(0, 12'hC81, 8'h5A, 1);
      aen_slot = 1'b0;
      io(0, 12'hC80, 8'h00, 0);
      reset_mode(3'h4);
      io(0, 12'h101, 8'h00, 0);
      cdsetup = 1'b1;
      io(0, 12'h101, 8'h5A, 1);
      io(1, 12'h102, 8'h21, 1);
      io(0, 12'h102, 8'h21, 1);
      aen_slot = 1'b1;
      reset_mode(3'h2);
      io(0, 12'hC80, 8'h00, 0);
      io(0, 12'h100, 8'h00, 0);
      reset_mode(3'h0);
      io(0, 12'hC80, 8'h00, 0);
      io(0, 12'h100, 8'h00, 0);
      {cdsetup, aen_slot} = 2'h0;
   endtask
   // FIFO filled until it refuses; a longer write stalls on empty and resumes
   task t_write;
      integer got, d;
      logic [63:0] e;
      prog(1'b1, 1'b0, 32'h0000_0100, 16'h0000);
      wt(0);
      push(0, 20, got);
      chk(got, 16);
      prog(1'b1, 1'b0, 32'h0000_0100, 16'h0014);
      wt(1);
      wt(2);
      chk(prog_ready, 0);
      push(16, 4, got);
      wt(0);
      for (d = 0; d < 40; d++)
      begin
         e = pat(d / 2);
         chk(i_hbms_host_model.mem[64 + d], d % 2 ? e[63:32] : e[31:0]);
      end
   endtask
   // Read stalls on a full FIFO while the local side holds off
   task t_read;
      prog(1'b0, 1'b0, 32'h0000_0100, 16'h0014);
      wt(1);
      wt(2);
      chk(prog_ready, 0);
      drain(20);
   endtask
   // Mailbox entry fetched and cleared; an empty entry is left alone
   task t_mbox;
      slow = 4'h2;
      i_hbms_host_model.mem[16] = 32'hCAFE_0001;
      prog(1'b0, 1'b1, 32'h0000_0040, 16'h0000);
      wt(0);
      chk({mbox_valid, mbox_entry}, {1'b1, 32'hCAFE_0001});
      chk(i_hbms_host_model.mem[16], 0);
      prog(1'b0, 1'b1, 32'h0000_0040, 16'h0000);
      wt(0);
      chk(mbox_valid, 0);
   endtask
   // Preemption in mid-transfer with a slow host
   task t_preempt;
      prog(1'b0, 1'b0, 32'h0000_0100, 16'h0008);
      wt(1);
      cyc(4);
      bus_preempt = 1'b1;
      wt(2);
      chk(prog_ready, 0);
      bus_preempt = 1'b0;
      drain(8);
      slow = 4'h0;
   endtask
   // Bus-on and bus-off of one tick each, written by the local side
   task t_buson;
      integer n, g;
      {lcfg_addr, lcfg_data, lcfg_wr} = {3'h2, 8'h01, 1'b1};
      cyc(1);
      {lcfg_addr, lcfg_data} = {3'h3, 8'h01};
      cyc(1);
      lcfg_wr = 1'b0;
      prog(1'b0, 1'b0, 32'h0000_0100, 16'h0010);
      wt(1);
      for (n = 0; master === 1'b1 && n < 200; n++)
         cyc(1);
      for (g = 0; g < 300 && !(g > 2 && bus_req === 1'b1); g++)
         cyc(1);
      chk(n >= 40 && n < 60, 1);
      chk(g >= 40 && g < 300, 1);
      drain(16);
   endtask
   // Main sequence
   initial
   begin
      {prog_valid, prog_to_mem, prog_mbox, loc_in_valid, loc_out_ready, bus_preempt} = 6'h00;
      {io_rd, io_wr, aen_slot, cdsetup, lcfg_wr, rst, mode_sel} = {5'h00, 1'b1, 3'h0};
      {prog_addr, prog_cnt, loc_in_data, io_addr, io_wdata, lcfg_addr, lcfg_data, slow} = '0;
      t_cfg;
      t_write;
      t_read;
      t_mbox;
      t_preempt;
      t_buson;
      give_verdict;
   end
endmodule
